// *** rtl/pmc_params.svh ***
// Constants for the power mode controller
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define APB_ADDR_W 12
`define REG_MODE_REQ 12'h000
`define REG_MODE_STAT 12'h004
`define REG_WAKE_EN 12'h008
`define REG_GPIO_RISE_EN 12'h00C
`define REG_GPIO_FALL_EN 12'h010
`define REG_SRAM_RET 12'h014
`define REG_CFG 12'h018
`define REG_WAKE_CAUSE 12'h01C

`define NUM_GPIO 42
`define NUM_PERIPH 16
`define NUM_BANKS 4

`define WAKE_GPIO 0
`define WAKE_UART 1
`define WAKE_TMR0 2
`define WAKE_TMR1 3
`define WAKE_RTC_SEC 4
`define WAKE_RTC_SUB 5
`define WAKE_PERIPH 6
`define NUM_WAKE 7

`define CFG_ECC 0
`define CFG_RTC_STORAGE 1

`define SRAM_RET_RESET 4'hF
`define WAKE_EN_RESET 7'h01
`define SRAM_FULL_KB 16'h00C8
`define SRAM_ECC_KB 16'h00A0

// Exit times in ns; counts in 5 ns cycles
`define CLK_PERIOD_NS 5
`define DEEP_EXIT_NS 200
`define BACKUP_EXIT_NS 1000
`define OSC_SETTLE_NS 100
`define DEEP_EXIT_CYC (`DEEP_EXIT_NS / `CLK_PERIOD_NS)
`define BACKUP_EXIT_CYC (`BACKUP_EXIT_NS / `CLK_PERIOD_NS)
`define OSC_SETTLE_CYC (`OSC_SETTLE_NS / `CLK_PERIOD_NS)
`define CNT_W 8

`endif

// *** rtl/pmc_pkg.sv ***
// Types for the power mode controller
package pmc_pkg;
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_SLEEP = 3'b001,
        MODE_RETAINED = 3'b010,
        MODE_BACKUP = 3'b011,
        MODE_STORAGE = 3'b100
    } mode_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b000,
        ST_SLEEP = 3'b001,
        ST_LOWPOWER = 3'b010,
        ST_WAKING = 3'b011,
        ST_OSC_START = 3'b100
    } state_t;
endpackage : pmc_pkg

// *** rtl/sync2.sv ***
// Two-flop synchroniser with edge outputs
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"

module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.meta = async_in;
        next_cur.sync = cur.meta;
        next_cur.prev = cur.sync;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign level = cur.sync;
    assign rise = cur.sync & ~cur.prev;
    assign fall = ~cur.sync & cur.prev;
endmodule : sync2
`default_nettype wire

// *** rtl/power_mode_controller.sv ***
// Power mode controller with APB registers and wake routing
// Notes on behaviour
// - Active: CPU runs, unused peripheral clocks gated off.
// - Sleep: CPU clock stopped, peripherals and DMA stay clocked.
// - Sleep: GPIO or enabled peripheral interrupt returns to active.
// - Retained sleep: CPU off, state and all SRAM kept; code powers only the banks set in sram_ret.
// - Retained sleep: GPIO outputs and configuration held from entry.
// - Retained sleep: system oscillators off, always-on sources remain.
// - Retained sleep: low-power UART and both timers may run and wake.
// - Retained sleep exit skips init, shorter than backup exit.
// - Backup: CPU off, same wake sources as retained sleep.
// - Backup: banks 0 and 1 partly kept, banks 2 and 3 fully; code powers only the banks set in sram_ret.
// - After resets or backup exit boot ranges of SRAM are lost.
// - Storage: CPU and peripherals off, no SRAM retained.
// - Storage: GPIO interrupt wakes the device.
// - SRAM retention selectable per bank.
// - Error correction on: usable SRAM shrinks to reduced capacity.
// - Crystal oscillators switched automatically by power mode.
// - Each GPIO wakes on enabled rising or falling edge; only GPIO 0 to 31 have writable enables, 32 to 41 never wake.
// - RTC seconds or sub-second alarm may wake the device.
// - Five software-selected modes: active to storage.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"

module power_mode_controller (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`NUM_GPIO-1:0] gpio_pin,
    input wire logic uart_wake,
    input wire logic tmr0_wake,
    input wire logic tmr1_wake,
    input wire logic rtc_sec_alarm,
    input wire logic rtc_sub_alarm,
    input wire logic [`NUM_PERIPH-1:0] periph_irq,
    input wire logic [`NUM_PERIPH-1:0] periph_busy,
    output logic cpu_clk_en,
    output logic cpu_pwr_en,
    output logic [`NUM_PERIPH-1:0] periph_clk_en,
    output logic periph_pwr_en,
    output logic dma_clk_en,
    output logic gpio_hold,
    output logic sys_osc_en,
    output logic xtal_hf_en,
    output logic xtal_rtc_en,
    output logic aon_clk_en,
    output logic lp_periph_en,
    output logic [`NUM_BANKS-1:0] bank_pwr_en,
    output logic bank01_partial,
    output logic boot_scratch_clr,
    output logic ecc_en,
    output logic [15:0] sram_size_kb,
    output logic cpu_wake
);
    typedef struct packed {
        pmc_pkg::state_t state;
        pmc_pkg::mode_t mode;
        pmc_pkg::mode_t target;
        logic [`NUM_WAKE-1:0] wake_en;
        logic [`NUM_GPIO-1:0] rise_en;
        logic [`NUM_GPIO-1:0] fall_en;
        logic [`NUM_BANKS-1:0] sram_ret;
        logic [1:0] cfg;
        logic [`NUM_WAKE-1:0] cause;
        logic [`CNT_W-1:0] cnt;
        logic from_backup;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic cpu_clk_en;
        logic cpu_pwr_en;
        logic [`NUM_PERIPH-1:0] periph_clk_en;
        logic periph_pwr_en;
        logic dma_clk_en;
        logic gpio_hold;
        logic sys_osc_en;
        logic xtal_hf_en;
        logic xtal_rtc_en;
        logic aon_clk_en;
        logic lp_periph_en;
        logic [`NUM_BANKS-1:0] bank_pwr_en;
        logic bank01_partial;
        logic boot_scratch_clr;
        logic ecc_en;
        logic [15:0] sram_size_kb;
        logic cpu_wake;
    } pmc_state_t;

    pmc_state_t cur;
    pmc_state_t next_cur;

    logic [`NUM_GPIO-1:0] gpio_lvl;
    logic [`NUM_GPIO-1:0] gpio_rise;
    logic [`NUM_GPIO-1:0] gpio_fall;
    logic [4:0] aon_lvl;
    logic [4:0] aon_rise;
    logic [`NUM_PERIPH-1:0] irq_lvl;
    logic [`NUM_PERIPH-1:0] busy_lvl;

    sync2 #(.WIDTH(`NUM_GPIO)) u_gpio_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in(gpio_pin),
        .level(gpio_lvl),
        .rise(gpio_rise),
        .fall(gpio_fall)
    );

    sync2 #(.WIDTH(5)) u_aon_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({rtc_sub_alarm, rtc_sec_alarm, tmr1_wake, tmr0_wake,
            uart_wake}),
        .level(aon_lvl),
        .rise(aon_rise),
        .fall()
    );

    sync2 #(.WIDTH(2 * `NUM_PERIPH)) u_periph_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({periph_busy, periph_irq}),
        .level({busy_lvl, irq_lvl}),
        .rise(),
        .fall()
    );

    logic [`NUM_WAKE-1:0] raw_wake;
    logic [`NUM_WAKE-1:0] allowed;
    logic [`NUM_WAKE-1:0] hit;
    logic apb_access;
    logic [`NUM_BANKS-1:0] ret_banks;
    logic [`NUM_WAKE-1:0] mode_sources;

    always_comb begin
        raw_wake = '0;
        raw_wake[`WAKE_GPIO] = |((gpio_rise & cur.rise_en)
            | (gpio_fall & cur.fall_en));
        raw_wake[`WAKE_UART] = aon_rise[0];
        raw_wake[`WAKE_TMR0] = aon_rise[1];
        raw_wake[`WAKE_TMR1] = aon_rise[2];
        raw_wake[`WAKE_RTC_SEC] = aon_rise[3];
        raw_wake[`WAKE_RTC_SUB] = aon_rise[4];
        raw_wake[`WAKE_PERIPH] = |irq_lvl;
        // Sources that can act in each low-power mode
        mode_sources = '0;
        case (cur.mode)
            pmc_pkg::MODE_SLEEP: begin
                mode_sources = '1;
            end
            pmc_pkg::MODE_RETAINED, pmc_pkg::MODE_BACKUP: begin
                mode_sources = '1;
                mode_sources[`WAKE_PERIPH] = 1'b0;
            end
            pmc_pkg::MODE_STORAGE: begin
                mode_sources[`WAKE_GPIO] = 1'b1;
                mode_sources[`WAKE_RTC_SEC] = cur.cfg[`CFG_RTC_STORAGE];
                mode_sources[`WAKE_RTC_SUB] = cur.cfg[`CFG_RTC_STORAGE];
            end
            default: begin
                mode_sources = '0;
            end
        endcase
        allowed = mode_sources & cur.wake_en;
        hit = raw_wake & allowed;
        ret_banks = cur.sram_ret;
        apb_access = psel & penable & cur.pready;
    end

    always_comb begin
        next_cur = cur;
        next_cur.pready = psel & ~cur.pready;
        next_cur.pslverr = 1'b0;
        next_cur.boot_scratch_clr = 1'b0;
        next_cur.cpu_wake = 1'b0;
        if (cur.cnt != '0) begin
            next_cur.cnt = cur.cnt - `CNT_W'(1);
        end

        // APB setup cycle prepares read data and error
        if (psel & ~cur.pready) begin
            next_cur.prdata = 32'h0000_0000;
            case (paddr)
                `REG_MODE_REQ: next_cur.prdata = {29'h0, cur.target};
                `REG_MODE_STAT: next_cur.prdata = {26'h0, cur.state, cur.mode};
                `REG_WAKE_EN: next_cur.prdata = {25'h0, cur.wake_en};
                `REG_GPIO_RISE_EN: next_cur.prdata = cur.rise_en[31:0];
                `REG_GPIO_FALL_EN: next_cur.prdata = cur.fall_en[31:0];
                `REG_SRAM_RET: next_cur.prdata = {28'h0, cur.sram_ret};
                `REG_CFG: next_cur.prdata = {30'h0, cur.cfg};
                `REG_WAKE_CAUSE: next_cur.prdata = {25'h0, cur.cause};
                default: next_cur.pslverr = 1'b1;
            endcase
        end
        if (apb_access & pwrite) begin
            case (paddr)
                `REG_MODE_REQ: begin
                    if (pwdata[2:0] <= 3'h4) begin
                        next_cur.target = pmc_pkg::mode_t'(pwdata[2:0]);
                    end
                end
                `REG_WAKE_EN: next_cur.wake_en = pwdata[`NUM_WAKE-1:0];
                `REG_GPIO_RISE_EN: next_cur.rise_en[31:0] = pwdata;
                `REG_GPIO_FALL_EN: next_cur.fall_en[31:0] = pwdata;
                `REG_SRAM_RET: next_cur.sram_ret = pwdata[`NUM_BANKS-1:0];
                `REG_CFG: next_cur.cfg = pwdata[1:0];
                `REG_WAKE_CAUSE: next_cur.cause = cur.cause & ~pwdata[6:0];
                default: next_cur.cfg = cur.cfg;
            endcase
        end

        case (cur.state)
            pmc_pkg::ST_ACTIVE: begin
                next_cur.mode = pmc_pkg::MODE_ACTIVE;
                if (cur.target != pmc_pkg::MODE_ACTIVE) begin
                    next_cur.mode = cur.target;
                    next_cur.target = pmc_pkg::MODE_ACTIVE;
                    next_cur.state = (cur.target == pmc_pkg::MODE_SLEEP) ?
                        pmc_pkg::ST_SLEEP : pmc_pkg::ST_LOWPOWER;
                end
            end
            pmc_pkg::ST_SLEEP: begin
                if (hit != '0) begin
                    next_cur.state = pmc_pkg::ST_ACTIVE;
                    next_cur.mode = pmc_pkg::MODE_ACTIVE;
                    next_cur.cpu_wake = 1'b1;
                end
            end
            pmc_pkg::ST_LOWPOWER: begin
                if (hit != '0) begin
                    next_cur.state = pmc_pkg::ST_OSC_START;
                    next_cur.cnt = `CNT_W'(`OSC_SETTLE_CYC);
                    next_cur.from_backup = (cur.mode != pmc_pkg::MODE_RETAINED);
                end
            end
            pmc_pkg::ST_OSC_START: begin
                if (cur.cnt == '0) begin
                    next_cur.state = pmc_pkg::ST_WAKING;
                    next_cur.cnt = cur.from_backup ?
                        `CNT_W'(`BACKUP_EXIT_CYC) : `CNT_W'(`DEEP_EXIT_CYC);
                    next_cur.boot_scratch_clr = cur.from_backup;
                end
            end
            pmc_pkg::ST_WAKING: begin
                if (cur.cnt == '0) begin
                    next_cur.state = pmc_pkg::ST_ACTIVE;
                    next_cur.mode = pmc_pkg::MODE_ACTIVE;
                    next_cur.cpu_wake = 1'b1;
                end
            end
            default: begin
                next_cur.state = pmc_pkg::ST_ACTIVE;
            end
        endcase
        // Hardware set wins over software clear
        next_cur.cause = next_cur.cause | hit;

        // Domain enables from the resulting state
        next_cur.cpu_clk_en = (next_cur.state == pmc_pkg::ST_ACTIVE);
        next_cur.cpu_pwr_en = (next_cur.state == pmc_pkg::ST_ACTIVE)
            | (next_cur.state == pmc_pkg::ST_SLEEP)
            | (next_cur.state == pmc_pkg::ST_WAKING);
        next_cur.periph_pwr_en = (next_cur.state != pmc_pkg::ST_LOWPOWER)
            | (next_cur.mode != pmc_pkg::MODE_STORAGE);
        next_cur.periph_clk_en = '0;
        if (next_cur.state == pmc_pkg::ST_ACTIVE) begin
            next_cur.periph_clk_en = busy_lvl;
        end else if (next_cur.state == pmc_pkg::ST_SLEEP) begin
            next_cur.periph_clk_en = '1;
        end
        next_cur.dma_clk_en = (next_cur.state == pmc_pkg::ST_ACTIVE)
            | (next_cur.state == pmc_pkg::ST_SLEEP);
        next_cur.sys_osc_en = (next_cur.state != pmc_pkg::ST_LOWPOWER);
        next_cur.xtal_hf_en = next_cur.sys_osc_en;
        next_cur.xtal_rtc_en = next_cur.sys_osc_en
            | (next_cur.mode != pmc_pkg::MODE_STORAGE)
            | cur.cfg[`CFG_RTC_STORAGE];
        next_cur.aon_clk_en = (next_cur.mode != pmc_pkg::MODE_STORAGE)
            | (next_cur.state != pmc_pkg::ST_LOWPOWER);
        next_cur.lp_periph_en = next_cur.aon_clk_en;
        next_cur.gpio_hold = (next_cur.state == pmc_pkg::ST_LOWPOWER)
            | (next_cur.state == pmc_pkg::ST_OSC_START);
        next_cur.bank_pwr_en = '1;
        next_cur.bank01_partial = 1'b0;
        if ((next_cur.state == pmc_pkg::ST_LOWPOWER)
            | (next_cur.state == pmc_pkg::ST_OSC_START)) begin
            case (next_cur.mode)
                pmc_pkg::MODE_RETAINED: next_cur.bank_pwr_en = ret_banks;
                pmc_pkg::MODE_BACKUP: begin
                    next_cur.bank_pwr_en = ret_banks;
                    next_cur.bank01_partial = 1'b1;
                end
                pmc_pkg::MODE_STORAGE: next_cur.bank_pwr_en = '0;
                default: next_cur.bank_pwr_en = '1;
            endcase
        end
        next_cur.ecc_en = cur.cfg[`CFG_ECC];
        next_cur.sram_size_kb = cur.cfg[`CFG_ECC] ?
            `SRAM_ECC_KB : `SRAM_FULL_KB;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
            cur.state <= pmc_pkg::ST_ACTIVE;
            cur.mode <= pmc_pkg::MODE_ACTIVE;
            cur.target <= pmc_pkg::MODE_ACTIVE;
            cur.wake_en <= `WAKE_EN_RESET;
            cur.sram_ret <= `SRAM_RET_RESET;
            cur.cpu_clk_en <= 1'b1;
            cur.cpu_pwr_en <= 1'b1;
            cur.periph_pwr_en <= 1'b1;
            cur.dma_clk_en <= 1'b1;
            cur.sys_osc_en <= 1'b1;
            cur.xtal_hf_en <= 1'b1;
            cur.xtal_rtc_en <= 1'b1;
            cur.aon_clk_en <= 1'b1;
            cur.lp_periph_en <= 1'b1;
            cur.bank_pwr_en <= '1;
            cur.boot_scratch_clr <= 1'b1;
            cur.sram_size_kb <= `SRAM_FULL_KB;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign cpu_clk_en = cur.cpu_clk_en;
    assign cpu_pwr_en = cur.cpu_pwr_en;
    assign periph_clk_en = cur.periph_clk_en;
    assign periph_pwr_en = cur.periph_pwr_en;
    assign dma_clk_en = cur.dma_clk_en;
    assign gpio_hold = cur.gpio_hold;
    assign sys_osc_en = cur.sys_osc_en;
    assign xtal_hf_en = cur.xtal_hf_en;
    assign xtal_rtc_en = cur.xtal_rtc_en;
    assign aon_clk_en = cur.aon_clk_en;
    assign lp_periph_en = cur.lp_periph_en;
    assign bank_pwr_en = cur.bank_pwr_en;
    assign bank01_partial = cur.bank01_partial;
    assign boot_scratch_clr = cur.boot_scratch_clr;
    assign ecc_en = cur.ecc_en;
    assign sram_size_kb = cur.sram_size_kb;
    assign cpu_wake = cur.cpu_wake;
endmodule : power_mode_controller
`default_nettype wire

// *** testbench/pmc_monitor.sv ***
// Port checker for the power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"

module pmc_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`NUM_PERIPH-1:0] periph_busy,
    input wire logic cpu_clk_en,
    input wire logic cpu_pwr_en,
    input wire logic [`NUM_PERIPH-1:0] periph_clk_en,
    input wire logic periph_pwr_en,
    input wire logic gpio_hold,
    input wire logic sys_osc_en,
    input wire logic xtal_hf_en,
    input wire logic lp_periph_en,
    input wire logic [`NUM_BANKS-1:0] bank_pwr_en,
    input wire logic bank01_partial,
    input wire logic ecc_en,
    input wire logic [15:0] sram_size_kb,
    input wire logic cpu_wake
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    property p_apb_answer;
        s_setup |=> s_access ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB answer late");
    property p_err_qual;
        pslverr |-> pready;
    endproperty
    a_err_qual: assert property (p_err_qual)
        else $error("pslverr without pready");
    property p_gate_busy;
        cpu_clk_en [*5] |-> periph_clk_en == $past(periph_busy, 3);
    endproperty
    a_gate_busy: assert property (p_gate_busy)
        else $error("peripheral clock gating wrong");
    property p_hold_cpu;
        gpio_hold |-> !cpu_clk_en;
    endproperty
    a_hold_cpu: assert property (p_hold_cpu)
        else $error("pins held while cpu clocked");
    property p_osc_off;
        $fell(cpu_pwr_en) |-> !sys_osc_en && !xtal_hf_en;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("system oscillator on in low power");
    property p_xtal_cpu;
        !xtal_hf_en |-> !cpu_pwr_en;
    endproperty
    a_xtal_cpu: assert property (p_xtal_cpu)
        else $error("crystal off while cpu powered");
    property p_storage;
        !periph_pwr_en |-> bank_pwr_en == '0 && !lp_periph_en;
    endproperty
    a_storage: assert property (p_storage)
        else $error("storage keeps power");
    property p_partial;
        bank01_partial |-> !cpu_clk_en && lp_periph_en;
    endproperty
    a_partial: assert property (p_partial)
        else $error("partial retention outside backup");
    property p_ecc_size;
        sram_size_kb == (ecc_en ? `SRAM_ECC_KB : `SRAM_FULL_KB);
    endproperty
    a_ecc_size: assert property (p_ecc_size)
        else $error("sram size mismatch");
    property p_wake_pulse;
        cpu_wake |=> !cpu_wake;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse too long");
endmodule : pmc_monitor

bind power_mode_controller pmc_monitor i_mon (.*);
`default_nettype wire

// *** testbench/wake_partner.sv ***
// Wake source model: pin edges and event pulses
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"

module wake_partner (
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic [2:0] src,
    input wire logic [4:0] pin,
    output logic [`NUM_GPIO-1:0] gpio_pin,
    output logic uart_wake,
    output logic tmr0_wake,
    output logic tmr1_wake,
    output logic rtc_sec_alarm,
    output logic rtc_sub_alarm,
    output logic [`NUM_PERIPH-1:0] periph_irq
);
    logic [6:0] ev = '0;
    logic [2:0] hold = '0;

    initial gpio_pin = '0;
    assign uart_wake = ev[1];
    assign tmr0_wake = ev[2];
    assign tmr1_wake = ev[3];
    assign rtc_sec_alarm = ev[4];
    assign rtc_sub_alarm = ev[5];
    assign periph_irq = {{(`NUM_PERIPH-1){1'b0}}, ev[6]};

    always @(posedge clk_sys) begin
        if (fire && src == 3'h0) begin
            gpio_pin[pin] <= !gpio_pin[pin];
        end else if (fire) begin
            ev[src] <= 1'b1;
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            ev <= '0;
        end
    end
endmodule : wake_partner
`default_nettype wire

// *** testbench/power_mode_controller_test.sv ***
// Self-checking bench for the power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"

module power_mode_controller_test;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [`APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, uart_wake, tmr0_wake, tmr1_wake, rtc_sec_alarm;
    logic rtc_sub_alarm, cpu_clk_en, cpu_pwr_en, periph_pwr_en, dma_clk_en;
    logic gpio_hold, sys_osc_en, xtal_hf_en, xtal_rtc_en, aon_clk_en;
    logic lp_periph_en, bank01_partial, boot_scratch_clr, ecc_en, cpu_wake;
    logic [`NUM_GPIO-1:0] gpio_pin;
    logic [`NUM_PERIPH-1:0] periph_irq, periph_clk_en;
    logic [`NUM_PERIPH-1:0] periph_busy = '0;
    logic [`NUM_BANKS-1:0] bank_pwr_en;
    logic [15:0] sram_size_kb;
    logic fire = 0, saw_clr = 0;
    logic [2:0] src = '0;
    logic [4:0] pin = '0;
    logic [7:0] lfsr = 8'h44;
    logic [33:0] rdq[$];
    logic [33:0] e;
    int err_count = 0, n_compared = 0, t_ret, t_bak, n;

    power_mode_controller i_dut (.*);
    wake_partner i_partner (.*);

    always #2.5 clk_sys = !clk_sys;
    always @(posedge clk_sys) if (boot_scratch_clr) saw_clr <= 1'b1;

    function automatic logic [7:0] lfsr_step(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_step

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Hold the request until pready is seen at a rising edge
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [11:0] a, input logic [32:0] x);
        rdq.push_back({!x[32], x});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : cyc

    task enter(input pmc_pkg::mode_t m);
        apb(1'b1, `REG_MODE_REQ, {29'h0, m});
        cyc(3);
    endtask : enter

    task wake(input int s, output int t);
        saw_clr = 0;
        lfsr = lfsr_step(lfsr);
        @(posedge clk_sys);
        fire <= 1'b1;
        src <= s[2:0];
        pin <= lfsr[4:0];
        @(posedge clk_sys);
        fire <= 1'b0;
        t = 0;
        do begin
            @(posedge clk_sys);
            #1;
            t++;
        end while (cpu_clk_en !== 1'b1 && t < 400);
    endtask : wake

    task end_sim;
        $display("Compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0) begin
            e = rdq.pop_front();
            check({31'h0, pslverr}, {31'h0, e[32]}, "pslverr");
            if (e[33]) check(prdata, e[31:0], "prdata");
        end
    end

    initial begin
        #200000;
        err_count++;
        end_sim;
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        cyc(2);
        check(sram_size_kb, `SRAM_FULL_KB, "sram size");
        rd(`REG_WAKE_EN, `WAKE_EN_RESET);
        rd(`REG_SRAM_RET, `SRAM_RET_RESET);
        rd(12'h0FC, {1'b1, 32'h0});
        apb(1'b1, `REG_CFG, 32'h1);
        cyc(3);
        check(sram_size_kb, `SRAM_ECC_KB, "ecc size");
        check(ecc_en, 1'b1, "ecc on");
        apb(1'b1, `REG_CFG, 32'h0);
        @(posedge clk_sys);
        periph_busy <= {lfsr, lfsr};
        cyc(8);
        check(periph_clk_en, {lfsr, lfsr}, "clock gating");
        apb(1'b1, `REG_GPIO_RISE_EN, 32'hFFFF_FFFF);
        apb(1'b1, `REG_GPIO_FALL_EN, 32'hFFFF_FFFF);
        apb(1'b1, `REG_WAKE_EN, 32'h7F);
        for (int s = 0; s < 7; s += 6) begin
            enter(pmc_pkg::MODE_SLEEP);
            rd(`REG_MODE_STAT, {27'h0, pmc_pkg::ST_SLEEP, pmc_pkg::MODE_SLEEP});
            check({cpu_clk_en, cpu_pwr_en, dma_clk_en}, 3'b011, "sleep");
            wake(s, n);
            check(cpu_clk_en, 1'b1, "sleep wake");
        end
        for (int s = 1; s < 6; s++) begin
            enter(pmc_pkg::MODE_RETAINED);
            check({gpio_hold, xtal_hf_en, sys_osc_en, cpu_pwr_en, aon_clk_en},
                  5'b10001, "retained");
            check({bank_pwr_en, lp_periph_en}, 5'h1F, "retained keep");
            wake(s, t_ret);
            check({cpu_clk_en, saw_clr}, 2'b10, "retained wake");
        end
        apb(1'b1, `REG_WAKE_EN, 32'h01);
        apb(1'b1, `REG_SRAM_RET, 32'h5);
        enter(pmc_pkg::MODE_RETAINED);
        check(bank_pwr_en, 4'h5, "bank select");
        wake(1, n);
        check(cpu_clk_en, 1'b0, "disabled source");
        wake(0, n);
        check(cpu_clk_en, 1'b1, "gpio wake");
        apb(1'b1, `REG_WAKE_EN, 32'h7F);
        apb(1'b1, `REG_SRAM_RET, 32'hF);
        enter(pmc_pkg::MODE_BACKUP);
        check({bank01_partial, bank_pwr_en, cpu_pwr_en}, 6'h3E, "backup");
        wake(3, t_bak);
        check({cpu_clk_en, saw_clr}, 2'b11, "backup wake");
        check(t_ret < t_bak, 1'b1, "exit order");
        enter(pmc_pkg::MODE_STORAGE);
        check({periph_pwr_en, lp_periph_en, xtal_rtc_en, bank_pwr_en},
              7'h00, "storage");
        wake(0, n);
        check({cpu_clk_en, saw_clr}, 2'b11, "storage wake");
        apb(1'b1, `REG_CFG, 32'h2);
        enter(pmc_pkg::MODE_STORAGE);
        check(xtal_rtc_en, 1'b1, "rtc kept");
        wake(4, n);
        check(cpu_clk_en, 1'b1, "alarm wake");
        check(rdq.size(), 0, "read queue");
        end_sim;
    end
endmodule : power_mode_controller_test
`default_nettype wire
